// ---- wcd_defs.svh ----
// Constants of the write check, inversion and mask path.
// Assumes: included by its bare name from the package and the design.
`ifndef WCD_DEFS_SVH
`define WCD_DEFS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define WCD_OFS_MODE_ONE   12'h000
`define WCD_OFS_MODE_FIVE  12'h004
`define WCD_OFS_READOUT3   12'h008
`define WCD_OFS_CONTROL    12'h00C
`define WCD_OFS_STATUS     12'h010

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define WCD_MW1_TERM_BIT   11
`define WCD_MW5_ERR_BIT    3
`define WCD_MW5_MASK_BIT   10
`define WCD_MW5_WINV_BIT   11
`define WCD_MW5_RINV_BIT   12
`define WCD_RO3_ERR_BIT    7
`define WCD_CTL_CRCEN_BIT  0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define WCD_RST_MODE_ONE   32'h0000_0000
`define WCD_RST_MODE_FIVE  32'h0000_0000
`define WCD_RST_CONTROL    32'h0000_0000

// -----------------------------------------------------------------
// Timing and check polynomial
// -----------------------------------------------------------------
`define WCD_PULSE_MIN_CK   6
`define WCD_PULSE_MAX_CK   10
`define WCD_PULSE_CK       8
`define WCD_CRC_POLY       8'h07

`endif

// ---- wcd_pkg.sv ----
// Types shared by the write check, inversion and mask path.
// Assumes: nothing beyond the constants header.
`include "wcd_defs.svh"

package wcd_pkg;

  // Error line driver state, one-hot
  typedef enum logic [1:0] {
    WCD_ALERT_IDLE  = 2'b01,
    WCD_ALERT_PULSE = 2'b10
  } wcd_alert_t;

  // Meaning carried by the shared per-lane pin
  typedef enum logic [1:0] {
    WCD_PIN_NONE   = 2'h0,
    WCD_PIN_MASK   = 2'h1,
    WCD_PIN_INVERT = 2'h2,
    WCD_PIN_TERM   = 2'h3
  } wcd_pin_t;

endpackage

// ---- wcd_write_path.sv ----
// Write data check, lane inversion and masking for one x8 byte lane.
// Assumes: one write burst is handed over in a single cycle on wrValid,
// APB master on the register port, error line pulled up outside.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "wcd_defs.svh"

// Overview of operation
// RULE_01: Chopped burst with A2 set: upper-half beats feed check, absent beats are ones.
// RULE_02: Compare own check over 72 bits with received check; signal next clock.
// RULE_03: Check errors use the shared active-low error line.
// RULE_04: Check error drives line low for six to ten clocks only.
// RULE_05: Controller tells errors apart by status read or pulse length.
// RULE_06: On check error set mode word five bit 3 and readout flag.
// RULE_07: Status bit and flag stay set until software writes bit 3 zero.
// RULE_08: Controller should reissue writes after a short error pulse.
// RULE_09: Controller measures error latency and buffers writes for replay.
// RULE_10: Controller tolerates longer low pulse when several devices report.
// RULE_11: Pulse width runs from driving low until the driver releases.
// RULE_12: Inversion only on writes; never on reads or readout.
// RULE_13: Controller enables at most one of inversion, masking, termination.
// RULE_14: Controller keeps read inversion disabled in mode word five.
// RULE_15: One pin per lane; enabled mode selects its meaning.
// RULE_16: Controller inverts bytes so fewer than half lines go low.
// RULE_17: Inversion pin low inverts the received byte; high stores unchanged.
// RULE_18: Mask enabled and pin low discards the byte; high writes it.
// RULE_19: Burst is eight beats; beat n carries byte n and pin bit n.
// RULE_20: Check and mask both on: error blocks the write, persistent mode.
// RULE_21: Check on, mask off: burst written even on a check error.
// RULE_22: Chopped with A2 set: beats four to seven take positions zero to three.
// RULE_23: Mask and inversion off: pin positions enter the check as ones.
// RULE_24: Check polynomial x^8+x^2+x+1 over the 72-bit input.
module wcd_write_path #(
  parameter int PULSE_CK = `WCD_PULSE_CK
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Write burst from the link
  input  wire logic        wrValid,
  input  wire logic [63:0] wrData,
  input  wire logic [7:0]  wrLanePin,
  input  wire logic [7:0]  wrCheck,
  input  wire logic        wrChop,
  input  wire logic        wrColA2,
  // Array write port
  output logic             memWe,
  output logic [63:0]      memData,
  output logic [7:0]       memByteEn,
  // Shared open-drain error line
  input  wire logic        errLineIn,
  output logic             errLineOut,
  output logic             errLineOe
);

  // -----------------------------------------------------------------
  // Check value over 72 bits, shifted in from the top bit
  // -----------------------------------------------------------------
  function automatic logic [7:0] calcCheck(input logic [71:0] din);
    logic [7:0] acc;
    logic       fb;
    acc = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      fb  = acc[7] ^ din[i];
      acc = {acc[6:0], 1'b0};
      if (fb) begin
        acc = acc ^ `WCD_CRC_POLY;
      end
    end
    return acc;
  endfunction

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic        termEn_ff,   nxt_termEn;
  logic        errStat_ff,  nxt_errStat;
  logic        maskEn_ff,   nxt_maskEn;
  logic        winvEn_ff,   nxt_winvEn;
  logic        crcEn_ff,    nxt_crcEn;
  logic        persist_ff,  nxt_persist;
  logic        pready_ff,   nxt_pready;
  logic [31:0] prdata_ff,   nxt_prdata;
  logic        pslverr_ff,  nxt_pslverr;

  // Write pipeline and error line state
  logic        memWe_ff,    nxt_memWe;
  logic [63:0] memData_ff,  nxt_memData;
  logic [7:0]  memByteEn_ff, nxt_memByteEn;
  logic        chkBad_ff,   nxt_chkBad;
  logic        errOe_ff,    nxt_errOe;
  logic [4:0]  pulseCnt_ff, nxt_pulseCnt;
  wcd_pkg::wcd_alert_t alertSt_ff, nxt_alertSt;

  // Decoded combinational terms
  wcd_pkg::wcd_pin_t pinMode;
  logic [71:0] checkIn;
  logic        mismatch;
  logic        wrAccess;
  logic        swClrErr;

  assign wrAccess = psel & penable & pwrite & ~pready_ff;

  // -----------------------------------------------------------------
  // Meaning of the shared lane pin
  // -----------------------------------------------------------------
  // RULE_15 one pin, mode selects
  always_comb begin
    if (maskEn_ff) begin
      pinMode = wcd_pkg::WCD_PIN_MASK;
    end else if (winvEn_ff) begin
      pinMode = wcd_pkg::WCD_PIN_INVERT;
    end else if (termEn_ff) begin
      pinMode = wcd_pkg::WCD_PIN_TERM;
    end else begin
      pinMode = wcd_pkg::WCD_PIN_NONE;
    end
  end

  // -----------------------------------------------------------------
  // Check input assembly and comparison
  // -----------------------------------------------------------------
  // Bit 8*lane+beat; lane 8 is the shared pin
  always_comb begin
    checkIn = {72{1'b1}};
    for (int bt = 0; bt < 8; bt++) begin
      // RULE_01 absent beats stay one
      if (!wrChop || bt < 4) begin
        for (int ln = 0; ln < 8; ln++) begin
          // RULE_19 RULE_22 beat n, upper beats moved down
          checkIn[8*ln+bt] = wrData[8*bt+ln+((wrChop && wrColA2) ? 32 : 0)];
        end
        // RULE_23 pin bits one when unused
        if (maskEn_ff || winvEn_ff) begin
          checkIn[64+bt] = wrLanePin[bt+((wrChop && wrColA2) ? 4 : 0)];
        end
      end
    end
  end

  // RULE_24 polynomial check
  // RULE_02 compare with received
  assign mismatch = crcEn_ff & wrValid & (calcCheck(checkIn) != wrCheck);

  // -----------------------------------------------------------------
  // Data path to the array
  // -----------------------------------------------------------------
  always_comb begin
    nxt_memWe     = 1'b0;
    nxt_memData   = memData_ff;
    nxt_memByteEn = 8'h00;
    nxt_chkBad    = mismatch;
    if (wrValid) begin
      nxt_memWe = 1'b1;
      for (int bt = 0; bt < 8; bt++) begin
        nxt_memData[8*bt +: 8] = wrData[8*bt +: 8];
        nxt_memByteEn[bt]      = 1'b1;
        // RULE_17 pin low inverts byte
        // RULE_12 inversion on writes only
        if (pinMode == wcd_pkg::WCD_PIN_INVERT && !wrLanePin[bt]) begin
          nxt_memData[8*bt +: 8] = ~wrData[8*bt +: 8];
        end
        // RULE_18 pin low drops byte
        if (pinMode == wcd_pkg::WCD_PIN_MASK && !wrLanePin[bt]) begin
          nxt_memByteEn[bt] = 1'b0;
        end
        // Chopped burst writes one half only
        if (wrChop && ((bt >= 4) != wrColA2)) begin
          nxt_memByteEn[bt] = 1'b0;
        end
      end
      // RULE_20 persistent mode blocks write
      if (mismatch && maskEn_ff) begin
        nxt_memWe     = 1'b0;
        nxt_memByteEn = 8'h00;
      end
      // RULE_21 non-persistent still writes
    end
  end

  // Array write registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      memWe_ff     <= 1'b0;
      memData_ff   <= 64'h0000_0000_0000_0000;
      memByteEn_ff <= 8'h00;
      chkBad_ff    <= 1'b0;
    end else begin
      memWe_ff     <= nxt_memWe;
      memData_ff   <= nxt_memData;
      memByteEn_ff <= nxt_memByteEn;
      chkBad_ff    <= nxt_chkBad;
    end
  end

  // -----------------------------------------------------------------
  // Error line pulse
  // -----------------------------------------------------------------
  // RULE_11 width counted while driving
  always_comb begin
    nxt_alertSt  = alertSt_ff;
    nxt_errOe    = errOe_ff;
    nxt_pulseCnt = pulseCnt_ff;
    case (alertSt_ff)
      wcd_pkg::WCD_ALERT_IDLE: begin
        // RULE_03 shared error line
        // RULE_02 starts clock after check
        if (chkBad_ff) begin
          nxt_alertSt  = wcd_pkg::WCD_ALERT_PULSE;
          nxt_errOe    = 1'b1;
          nxt_pulseCnt = 5'(PULSE_CK - 1);
        end
      end
      wcd_pkg::WCD_ALERT_PULSE: begin
        // RULE_04 short low pulse
        if (pulseCnt_ff == 5'h00) begin
          nxt_alertSt = wcd_pkg::WCD_ALERT_IDLE;
          nxt_errOe   = 1'b0;
        end else begin
          nxt_pulseCnt = pulseCnt_ff - 5'h01;
        end
      end
      default: begin
        nxt_alertSt  = wcd_pkg::WCD_ALERT_IDLE;
        nxt_errOe    = 1'b0;
        nxt_pulseCnt = 5'h00;
      end
    endcase
  end

  // Error line registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alertSt_ff  <= wcd_pkg::WCD_ALERT_IDLE;
      errOe_ff    <= 1'b0;
      pulseCnt_ff <= 5'h00;
    end else begin
      alertSt_ff  <= nxt_alertSt;
      errOe_ff    <= nxt_errOe;
      pulseCnt_ff <= nxt_pulseCnt;
    end
  end

  // -----------------------------------------------------------------
  // APB registers
  // -----------------------------------------------------------------
  assign swClrErr = wrAccess && paddr == `WCD_OFS_MODE_FIVE &&
                    !pwdata[`WCD_MW5_ERR_BIT];

  // Register next values and read answer
  always_comb begin
    nxt_termEn  = termEn_ff;
    nxt_maskEn  = maskEn_ff;
    nxt_winvEn  = winvEn_ff;
    nxt_crcEn   = crcEn_ff;
    nxt_pready  = psel & penable & ~pready_ff;
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (wrAccess) begin
      case (paddr)
        `WCD_OFS_MODE_ONE: begin
          nxt_termEn = pwdata[`WCD_MW1_TERM_BIT];
        end
        `WCD_OFS_MODE_FIVE: begin
          nxt_maskEn = pwdata[`WCD_MW5_MASK_BIT];
          nxt_winvEn = pwdata[`WCD_MW5_WINV_BIT];
        end
        `WCD_OFS_CONTROL: begin
          nxt_crcEn = pwdata[`WCD_CTL_CRCEN_BIT];
        end
        `WCD_OFS_READOUT3, `WCD_OFS_STATUS: begin
          nxt_pslverr = 1'b0;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && !pready_ff) begin
      case (paddr)
        `WCD_OFS_MODE_ONE: begin
          nxt_prdata[`WCD_MW1_TERM_BIT] = termEn_ff;
        end
        `WCD_OFS_MODE_FIVE: begin
          nxt_prdata[`WCD_MW5_ERR_BIT]  = errStat_ff;
          nxt_prdata[`WCD_MW5_MASK_BIT] = maskEn_ff;
          nxt_prdata[`WCD_MW5_WINV_BIT] = winvEn_ff;
        end
        `WCD_OFS_READOUT3: begin
          // RULE_06 mirrored flag
          nxt_prdata[`WCD_RO3_ERR_BIT] = errStat_ff;
        end
        `WCD_OFS_CONTROL: begin
          nxt_prdata[`WCD_CTL_CRCEN_BIT] = crcEn_ff;
        end
        `WCD_OFS_STATUS: begin
          nxt_prdata[0] = errOe_ff;
          nxt_prdata[1] = errLineIn;
          nxt_prdata[2] = persist_ff;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  // Sticky error status, set wins over clear
  always_comb begin
    nxt_errStat = errStat_ff;
    nxt_persist = persist_ff;
    // RULE_07 held until written zero
    if (swClrErr) begin
      nxt_errStat = 1'b0;
      nxt_persist = 1'b0;
    end
    // RULE_06 set on check error
    if (mismatch) begin
      nxt_errStat = 1'b1;
      nxt_persist = persist_ff | maskEn_ff;
    end
  end

  // Register file flip-flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      termEn_ff  <= 1'(`WCD_RST_MODE_ONE >> `WCD_MW1_TERM_BIT);
      maskEn_ff  <= 1'b0;
      winvEn_ff  <= 1'b0;
      crcEn_ff   <= 1'b0;
      errStat_ff <= 1'b0;
      persist_ff <= 1'b0;
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      termEn_ff  <= nxt_termEn;
      maskEn_ff  <= nxt_maskEn;
      winvEn_ff  <= nxt_winvEn;
      crcEn_ff   <= nxt_crcEn;
      errStat_ff <= nxt_errStat;
      persist_ff <= nxt_persist;
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign pready     = pready_ff;
  assign prdata     = prdata_ff;
  assign pslverr    = pslverr_ff;
  assign memWe      = memWe_ff;
  assign memData    = memData_ff;
  assign memByteEn  = memByteEn_ff;
  assign errLineOe  = errOe_ff;  // Open drain: only ever pulls low
  assign errLineOut = 1'b0;

endmodule

// ---- wcd_write_path_sva.sv ----
// Checker of the write path ports: bus answer, array write, error pulse.
// Assumes: one clock, synchronous active-low reset, bound below.
`timescale 1ns/1ps
module wcd_write_path_sva #(
  parameter int PULSE_CK = 8
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Burst, array and error line
  input wire logic        wrValid,
  input wire logic        memWe,
  input wire logic        errLineOut,
  input wire logic        errLineOe
);
  logic [7:0] hiCnt_ff;
  logic [7:0] nxt_hiCnt;
  // Cycles the line has been pulled low
  always_comb begin
    nxt_hiCnt = (rst_n && errLineOe) ? hiCnt_ff + 8'h01 : 8'h00;
  end
  always_ff @(posedge mclk) begin
    hiCnt_ff <= nxt_hiCnt;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ack; psel && penable && !pready |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("bus answer missing");
  property p_ack_one; pready |=> !pready; endproperty
  a_ack_one: assert property (p_ack_one) else $error("answer too long");
  property p_err_ans; pslverr |-> pready; endproperty
  a_err_ans: assert property (p_err_ans) else $error("stray bus error");
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
  property p_we_cause; memWe |-> $past(wrValid); endproperty
  a_we_cause: assert property (p_we_cause) else $error("stray write");
  property p_line_low; errLineOe |-> !errLineOut; endproperty
  a_line_low: assert property (p_line_low) else $error("line not low");
  property p_pulse_len; $fell(errLineOe) |-> hiCnt_ff == 8'(PULSE_CK);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width");
  property p_pulse_min; $rose(errLineOe) |-> errLineOe [*6]; endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("pulse short");
  property p_latency; $rose(errLineOe) |-> $past(wrValid, 2); endproperty
  a_latency: assert property (p_latency) else $error("pulse latency");
  c_pulse: cover property ($rose(errLineOe));
  c_write: cover property (memWe);
  c_slverr: cover property (pslverr);
endmodule

bind wcd_write_path wcd_write_path_sva #(.PULSE_CK(PULSE_CK))
  wcd_write_path_sva_inst (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .wrValid(wrValid), .memWe(memWe), .errLineOut(errLineOut),
  .errLineOe(errLineOe));

// ---- wcd_ctrl_model.sv ----
// Controller model: sends write bursts, watches the shared error line.
// Assumes: device clock shared, error line pulled up inside this model.
`timescale 1ns/1ps
module wcd_ctrl_model (
  // Clock
  input  wire logic   mclk,
  // Burst to the device
  output logic        wrValid,
  output logic [63:0] wrData,
  output logic [7:0]  wrLanePin,
  output logic [7:0]  wrCheck,
  output logic        wrChop,
  output logic        wrColA2,
  // Error line
  input  wire logic   errLineOut,
  input  wire logic   errLineOe,
  output logic        errLineIn,
  output int          lowLen
);
  int run;
  assign errLineIn = errLineOe ? errLineOut : 1'b1;
  always @(posedge mclk) begin
    run <= errLineIn ? 0 : run + 1;
    if (errLineIn && run != 0) lowLen <= run;
  end
  initial begin
    {wrValid, wrChop, wrColA2} = 3'h0;
    {wrData, wrLanePin, wrCheck} = 80'h0;
  end
  function automatic logic [7:0] crc8(logic [63:0] d, logic [7:0] p,
      logic ch, logic a2, logic pu);
    logic [71:0] v;
    logic [7:0]  c;
    int          s;
    c = 8'h00;
    for (int b = 0; b < 8; b++) begin
      s = (ch && a2) ? b + 4 : b;
      for (int l = 0; l < 8; l++)
        v[8*l+b] = (ch && b > 3) ? 1'b1 : d[8*s+l];
      v[64+b] = ((ch && b > 3) || !pu) ? 1'b1 : p[s];
    end
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Invert lanes with more zeros than ones, pin low
  function automatic logic [71:0] inv_enc(logic [63:0] raw);
    logic [71:0] r;
    r = {8'hFF, raw};
    for (int b = 0; b < 8; b++) begin
      if ($countones(raw[8*b +: 8]) < 4) begin
        r[8*b +: 8] = ~raw[8*b +: 8];
        r[64+b]     = 1'b0;
      end
    end
    return r;
  endfunction
  // One whole burst per valid cycle
  task automatic send(input logic [63:0] d, input logic [7:0] p,
      input logic ch, a2, pu, bad);
    @(posedge mclk);
    wrValid <= 1'b1;
    wrData <= d;
    wrLanePin <= p;
    {wrChop, wrColA2} <= {ch, a2};
    wrCheck <= crc8(d, p, ch, a2, pu) ^ {7'h00, bad};
    @(posedge mclk);
    wrValid <= 1'b0;
    wrData <= ~d;
    wrLanePin <= ~p;
    wrCheck <= ~wrCheck;
  endtask
endmodule

// ---- dram_write_crc_dbi_mask_bench.sv ----
// Bench of the write path: bus tasks, burst scenarios, verdict.
// Assumes: controller model drives bursts, checker is bound.
`timescale 1ns/1ps
`include "wcd_defs.svh"
module dram_write_crc_dbi_mask_bench;
  localparam int          PK = 8;
  localparam logic [63:0] D  = 64'h0123_4567_89AB_CDEF;
  // Clock, reset and bus
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  // Burst, array and line
  logic        wrValid, wrChop, wrColA2, memWe;
  logic        errLineIn, errLineOut, errLineOe;
  logic [63:0] wrData, memData;
  logic [7:0]  wrLanePin, wrCheck, memByteEn;
  int          mismatches, checked;

  wcd_write_path #(.PULSE_CK(PK)) wcd_write_path_inst (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .wrValid(wrValid),
    .wrData(wrData), .wrLanePin(wrLanePin), .wrCheck(wrCheck),
    .wrChop(wrChop), .wrColA2(wrColA2), .memWe(memWe),
    .memData(memData), .memByteEn(memByteEn), .errLineIn(errLineIn),
    .errLineOut(errLineOut), .errLineOe(errLineOe));
  wcd_ctrl_model wcd_ctrl_model_inst (
    .mclk(mclk), .wrValid(wrValid), .wrData(wrData),
    .wrLanePin(wrLanePin), .wrCheck(wrCheck), .wrChop(wrChop),
    .wrColA2(wrColA2), .errLineOut(errLineOut),
    .errLineOe(errLineOe), .errLineIn(errLineIn), .lowLen());

  always #5 mclk = ~mclk;

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; read data and error land in rv and ev
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
    rv = prdata;
    ev = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic send(input logic [7:0] p, input logic ch, a2, pu, bad);
    wcd_ctrl_model_inst.send(D, p, ch, a2, pu, bad);
    #1;
  endtask
  task automatic line_after(input logic exp);
    @(posedge mclk);
    #1;
    chk(64'(errLineOe), 64'(exp));
  endtask

  task automatic t_reset;
    apb(1'b0, `WCD_OFS_MODE_FIVE, 32'h0);
    chk(64'(rv), 64'(`WCD_RST_MODE_FIVE));
    apb(1'b0, `WCD_OFS_CONTROL, 32'h0);
    chk(64'(rv), 64'(`WCD_RST_CONTROL));
    apb(1'b0, 12'h020, 32'h0);
    chk({rv, 31'h0, ev}, 64'h1);
  endtask
  task automatic t_plain;
    apb(1'b1, `WCD_OFS_CONTROL, 32'h1);
    send(8'hA5, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(64'({memWe, memByteEn}), 64'h1FF);
    chk(memData, D);
    line_after(1'b0);
  endtask
  task automatic t_chop;
    logic [63:0] m;
    for (int a = 0; a < 2; a++) begin
      m = a ? 64'hFFFF_FFFF_0000_0000 : 64'h0000_0000_FFFF_FFFF;
      send(8'hFF, 1'b1, a[0], 1'b0, 1'b0);
      chk(64'(memByteEn), a ? 64'hF0 : 64'h0F);
      chk(memData & m, D & m);
      line_after(1'b0);
    end
  endtask
  task automatic t_invert;
    logic [71:0] e;
    apb(1'b1, `WCD_OFS_MODE_FIVE, 32'h800);
    apb(1'b0, `WCD_OFS_MODE_FIVE, 32'h0);
    chk(64'(rv), 64'h800);
    // Pins low on beats 0, 1, 6 and 7
    send(8'h3C, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(memData, D ^ 64'hFFFF_0000_0000_FFFF);
    chk(64'(memByteEn), 64'hFF);
    line_after(1'b0);
    // Controller encodes the lanes itself; array gets raw data
    e = wcd_ctrl_model_inst.inv_enc(D);
    wcd_ctrl_model_inst.send(e[63:0], e[71:64], 1'b0, 1'b0, 1'b1, 1'b0);
    #1;
    chk(memData, D);
    line_after(1'b0);
  endtask
  task automatic t_error;
    apb(1'b1, `WCD_OFS_MODE_FIVE, 32'h0);
    send(8'hFF, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(64'({memWe, memByteEn}), 64'h1FF);
    line_after(1'b1);
    repeat (10) @(posedge mclk);
    #1;
    chk(64'(wcd_ctrl_model_inst.lowLen), 64'(PK));
    apb(1'b0, `WCD_OFS_READOUT3, 32'h0);
    chk(64'(rv[7]), 64'h1);
    send(8'hFF, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(64'(memWe), 64'h1);
    line_after(1'b0);
    apb(1'b0, `WCD_OFS_MODE_FIVE, 32'h0);
    chk(64'(rv[3]), 64'h1);
    apb(1'b1, `WCD_OFS_MODE_FIVE, 32'h0);
    apb(1'b0, `WCD_OFS_READOUT3, 32'h0);
    chk(64'(rv[7]), 64'h0);
  endtask
  task automatic t_mask;
    apb(1'b1, `WCD_OFS_MODE_FIVE, 32'h400);
    send(8'h5A, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(64'(memByteEn), 64'h5A);
    chk(memData & 64'h00FF_00FF_FF00_FF00,
        D & 64'h00FF_00FF_FF00_FF00);
    send(8'h5A, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(64'(memWe), 64'h0);
    line_after(1'b1);
    repeat (10) @(posedge mclk);
    apb(1'b0, `WCD_OFS_MODE_FIVE, 32'h0);
    chk(64'(rv), 64'h408);
    // Status: persistent flag set, line released and high
    apb(1'b0, `WCD_OFS_STATUS, 32'h0);
    chk(64'(rv), 64'h6);
  endtask
  task automatic t_term;
    apb(1'b1, `WCD_OFS_MODE_ONE, 32'h800);
    apb(1'b0, `WCD_OFS_MODE_ONE, 32'h0);
    chk(64'(rv), 64'h800);
    // Pins low carry no mask or inversion meaning here
    send(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(64'({memWe, memByteEn}), 64'h1FF);
    chk(memData, D);
    line_after(1'b0);
    apb(1'b1, `WCD_OFS_MODE_ONE, 32'h0);
  endtask

  initial begin
    {mclk, rst_n, psel, penable, pwrite} = 5'h0;
    {paddr, pwdata} = 44'h0;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_plain();
    t_chop();
    t_invert();
    t_error();
    t_term();
    t_mask();
    tally_and_finish();
  end
endmodule
